// *** verilog/dac_ctrl_pkg.sv ***
// Purpose: Shared constants for the two-channel DAC output control block.
// Assumes: APB slave with 32-bit data; each register index sits at byte address index*4.
// Notes:   Pin configuration survives a hot start and is cleared on a cold start.
// Notes on behaviour
// - Enable bit one: channel converts its stored code and drives its pin.
// - Enable bit zero: conversion off, analog pin held high impedance.
// - Reset clears both enable bits; enable bits read back as written.
// - Enable register: channel 0 at D1, channel 1 at D0, D7-D2 read zero.
// - Rewriting a code while enabled converts the new code without toggling.
// - Two 8-bit read/write code registers, channel 1 one index (four bytes) below channel 0.
// - Reset clears both code registers to zero.
// - Code is unsigned 0..255, D7 most significant, output is code/256 of reference.
// - Voltage select D0: one is 5 V, zero 3.3 V, shared, resets zero.
// - Function bits D3/D4 route pins A/B to channel 0/1 when one.
// - Function bits clear on cold start, keep value on hot start.
// - Pull-up bits D3/D4 enable pin pull-ups; cold clear, hot keep.
// - Function and pull-up registers are write-only; software stores whole bytes.
// - Port data read of a pin assigned to analog output returns zero.
package dac_ctrl_pkg;

  localparam int          DATA_W       = 32;
  localparam int          CODE_W       = 8;

  // Printed register indices; byte address is four times the index
  localparam logic [31:0] IDX_OUT_EN   = 32'h0004_0246;
  localparam logic [31:0] IDX_VSEL     = 32'h0004_0247;
  localparam logic [31:0] IDX_CODE1    = 32'h0004_0248;
  localparam logic [31:0] IDX_CODE0    = 32'h0004_0249;
  localparam logic [31:0] IDX_PIN_FUNC = 32'h0004_02c0;
  localparam logic [31:0] IDX_PULLUP   = 32'h0004_02c4;

  // Field positions
  localparam int          EN_CH0_BIT   = 1;
  localparam int          EN_CH1_BIT   = 0;
  localparam int          VSEL_BIT     = 0;
  localparam int          PIN_A_BIT    = 3;
  localparam int          PIN_B_BIT    = 4;

  // Reset values
  localparam logic [7:0]  CODE_RST     = 8'h00;
  localparam logic        EN_RST       = 1'b0;
  localparam logic        VSEL_RST     = 1'b0;
  localparam logic        PIN_CFG_RST  = 1'b0;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    byte_addr = {idx[29:0], 2'b00};
  endfunction

endpackage

// *** verilog/port_pin_config.sv ***
// Purpose: Function-select and pull-up bits of the two shared port pins.
// Assumes: Clock runs while RESETN_I is low; COLD_START_I is steady across reset.
// Notes:   No asynchronous reset here so the bits survive a hot start.
`timescale 1ns/1ps
module port_pin_config
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic cold_start_i,
  // Write port
  input  wire logic wr_func_i,
  input  wire logic wr_pullup_i,
  input  wire logic bit_a_i,
  input  wire logic bit_b_i,
  // Held settings
  output logic      func_a_o,
  output logic      func_b_o,
  output logic      pullup_a_o,
  output logic      pullup_b_o
);
  import dac_ctrl_pkg::*;

  logic rst_meta;
  logic rst_sync;
  logic cold_meta;
  logic cold_sync;
  logic next_func_a;
  logic next_func_b;
  logic next_pullup_a;
  logic next_pullup_b;

  // Reset and strap level caught by plain synchronisers, no reset on them
  always_ff @(posedge clk_i)
  begin
    rst_meta  <= ~resetn_i;
    rst_sync  <= rst_meta;
    cold_meta <= cold_start_i;
    cold_sync <= cold_meta;
  end

  always_comb
  begin
    next_func_a   = func_a_o;
    next_func_b   = func_b_o;
    next_pullup_a = pullup_a_o;
    next_pullup_b = pullup_b_o;
    if (rst_sync)
    begin
      if (cold_sync)
      begin
        next_func_a   = PIN_CFG_RST;
        next_func_b   = PIN_CFG_RST;
        next_pullup_a = PIN_CFG_RST;
        next_pullup_b = PIN_CFG_RST;
      end
    end
    else
    begin
      if (wr_func_i)
      begin
        next_func_a = bit_a_i;
        next_func_b = bit_b_i;
      end
      if (wr_pullup_i)
      begin
        next_pullup_a = bit_a_i;
        next_pullup_b = bit_b_i;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    func_a_o   <= next_func_a;
    func_b_o   <= next_func_b;
    pullup_a_o <= next_pullup_a;
    pullup_b_o <= next_pullup_b;
  end

endmodule // port_pin_config

// *** verilog/dac_output_control.sv ***
// Purpose: APB register side of a two-channel 8-bit DAC with shared port pins.
// Assumes: Single 250 MHz clock; pins PORT_*_I are asynchronous.
// Notes:   Zero-wait APB; read data and slave error are prepared in the setup cycle.
`timescale 1ns/1ps
module dac_output_control
(
  // Clock and reset
  input  wire logic                        CLK_I,
  input  wire logic                        RESETN_I,
  input  wire logic                        COLD_START_I,
  // APB slave
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [31:0]                 PADDR_I,
  input  wire logic [dac_ctrl_pkg::DATA_W-1:0] PWDATA_I,
  input  wire logic [3:0]                  PSTRB_I,
  output logic      [dac_ctrl_pkg::DATA_W-1:0] PRDATA_O,
  output logic                             PREADY_O,
  output logic                             PSLVERR_O,
  // Converter channels
  output logic      [dac_ctrl_pkg::CODE_W-1:0] CH0_CODE_O,
  output logic      [dac_ctrl_pkg::CODE_W-1:0] CH1_CODE_O,
  output logic                             CH0_CONVERT_O,
  output logic                             CH1_CONVERT_O,
  output logic                             SUPPLY_5V_SELECT_O,
  // Shared port pins
  input  wire logic                        PORT_PIN_A_I,
  input  wire logic                        PORT_PIN_B_I,
  output logic                             ANALOG_OUT_CH0_OE_O,
  output logic                             ANALOG_OUT_CH1_OE_O,
  output logic                             PIN_A_FUNCTION_SELECT_O,
  output logic                             PIN_B_FUNCTION_SELECT_O,
  output logic                             PIN_A_PULLUP_ENABLE_O,
  output logic                             PIN_B_PULLUP_ENABLE_O,
  output logic                             PORT_PIN_A_DATA_O,
  output logic                             PORT_PIN_B_DATA_O
);
  import dac_ctrl_pkg::*;

  // Register state
  logic [CODE_W-1:0] ch0_code_register;
  logic [CODE_W-1:0] ch1_code_register;
  logic              ch0_output_enable;
  logic              ch1_output_enable;
  logic              supply_voltage_select;
  logic [CODE_W-1:0] next_ch0_code;
  logic [CODE_W-1:0] next_ch1_code;
  logic              next_ch0_en;
  logic              next_ch1_en;
  logic              next_vsel;

  // Bus state
  logic [DATA_W-1:0] next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              setup;
  logic              wr_done;
  logic              hit_en;
  logic              hit_vsel;
  logic              hit_code0;
  logic              hit_code1;
  logic              hit_func;
  logic              hit_pullup;
  logic              mapped;

  // Pin state
  logic              pin_a_meta;
  logic              pin_b_meta;
  logic              pin_a_sync;
  logic              pin_b_sync;
  logic              next_data_a;
  logic              next_data_b;
  logic              func_a;
  logic              func_b;

  // Address decode
  always_comb
  begin
    setup      = PSEL_I & ~PENABLE_I;
    wr_done    = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & PSTRB_I[0];
    hit_en     = (PADDR_I == byte_addr(IDX_OUT_EN));
    hit_vsel   = (PADDR_I == byte_addr(IDX_VSEL));
    hit_code0  = (PADDR_I == byte_addr(IDX_CODE0));
    hit_code1  = (PADDR_I == byte_addr(IDX_CODE1));
    hit_func   = (PADDR_I == byte_addr(IDX_PIN_FUNC));
    hit_pullup = (PADDR_I == byte_addr(IDX_PULLUP));
    mapped     = hit_en | hit_vsel | hit_code0 | hit_code1 | hit_func | hit_pullup;
  end

  // Register next values; a write lands on the edge that completes the access
  always_comb
  begin
    next_ch0_code = ch0_code_register;
    next_ch1_code = ch1_code_register;
    next_ch0_en   = ch0_output_enable;
    next_ch1_en   = ch1_output_enable;
    next_vsel     = supply_voltage_select;
    if (wr_done)
    begin
      if (hit_code0)
      begin
        next_ch0_code = PWDATA_I[CODE_W-1:0];
      end
      if (hit_code1)
      begin
        next_ch1_code = PWDATA_I[CODE_W-1:0];
      end
      if (hit_en)
      begin
        next_ch0_en = PWDATA_I[EN_CH0_BIT];
        next_ch1_en = PWDATA_I[EN_CH1_BIT];
      end
      if (hit_vsel)
      begin
        next_vsel = PWDATA_I[VSEL_BIT];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ch0_code_register     <= CODE_RST;
      ch1_code_register     <= CODE_RST;
      ch0_output_enable     <= EN_RST;
      ch1_output_enable     <= EN_RST;
      supply_voltage_select <= VSEL_RST;
    end
    else
    begin
      ch0_code_register     <= next_ch0_code;
      ch1_code_register     <= next_ch1_code;
      ch0_output_enable     <= next_ch0_en;
      ch1_output_enable     <= next_ch1_en;
      supply_voltage_select <= next_vsel;
    end
  end

  // Read data is built in the setup cycle so it can come out of a flop
  always_comb
  begin
    next_prdata  = PRDATA_O;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (setup)
    begin
      next_pready  = 1'b1;
      next_pslverr = ~mapped;
      next_prdata  = WORD_ZERO;
      if (hit_en)
      begin
        next_prdata[EN_CH0_BIT] = ch0_output_enable;
        next_prdata[EN_CH1_BIT] = ch1_output_enable;
      end
      if (hit_vsel)
      begin
        // Undefined bit D1 is returned as zero
        next_prdata[VSEL_BIT] = supply_voltage_select;
      end
      if (hit_code0)
      begin
        next_prdata[CODE_W-1:0] = ch0_code_register;
      end
      if (hit_code1)
      begin
        next_prdata[CODE_W-1:0] = ch1_code_register;
      end
      // Write-only registers read as zero, which software must not rely on
      if (hit_func | hit_pullup)
      begin
        next_prdata = WORD_ZERO;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      PRDATA_O  <= WORD_ZERO;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PRDATA_O  <= next_prdata;
      PREADY_O  <= next_pready;
      PSLVERR_O <= next_pslverr;
    end
  end

  // Pin function and pull-up bits keep their value over a hot start
  port_pin_config u_pin_cfg
  (
    .clk_i        (CLK_I),
    .resetn_i     (RESETN_I),
    .cold_start_i (COLD_START_I),
    .wr_func_i    (wr_done & hit_func),
    .wr_pullup_i  (wr_done & hit_pullup),
    .bit_a_i      (PWDATA_I[PIN_A_BIT]),
    .bit_b_i      (PWDATA_I[PIN_B_BIT]),
    .func_a_o     (func_a),
    .func_b_o     (func_b),
    .pullup_a_o   (PIN_A_PULLUP_ENABLE_O),
    .pullup_b_o   (PIN_B_PULLUP_ENABLE_O)
  );

  // Port data path: pins are asynchronous, so two flops before any logic
  always_comb
  begin
    next_data_a = pin_a_sync & ~func_a;
    next_data_b = pin_b_sync & ~func_b;
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pin_a_meta        <= 1'b0;
      pin_b_meta        <= 1'b0;
      pin_a_sync        <= 1'b0;
      pin_b_sync        <= 1'b0;
      PORT_PIN_A_DATA_O <= 1'b0;
      PORT_PIN_B_DATA_O <= 1'b0;
    end
    else
    begin
      pin_a_meta        <= PORT_PIN_A_I;
      pin_b_meta        <= PORT_PIN_B_I;
      pin_a_sync        <= pin_a_meta;
      pin_b_sync        <= pin_b_meta;
      PORT_PIN_A_DATA_O <= next_data_a;
      PORT_PIN_B_DATA_O <= next_data_b;
    end
  end

  // Outputs taken straight from the register flops so the converter
  // sees a new code or enable in the same cycle the register changes
  always_comb
  begin
    CH0_CODE_O              = ch0_code_register;
    CH1_CODE_O              = ch1_code_register;
    CH0_CONVERT_O           = ch0_output_enable;
    CH1_CONVERT_O           = ch1_output_enable;
    // Pin drive follows the enable alone; high impedance whenever it is zero
    ANALOG_OUT_CH0_OE_O     = ch0_output_enable;
    ANALOG_OUT_CH1_OE_O     = ch1_output_enable;
    SUPPLY_5V_SELECT_O      = supply_voltage_select;
    PIN_A_FUNCTION_SELECT_O = func_a;
    PIN_B_FUNCTION_SELECT_O = func_b;
  end

endmodule // dac_output_control

// *** bench/dac_ctrl_sva.sv ***
// Purpose: Port-level checks of the DAC control block.
// Assumes: Zero-wait APB; byte address is four times the index.
// Notes:   D1 of the voltage register is never checked.
`timescale 1ns/1ps
module dac_ctrl_sva
(
  // Watched ports
  input wire logic        CLK_I, RESETN_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O,
  input wire logic        CH0_CONVERT_O, CH1_CONVERT_O, SUPPLY_5V_SELECT_O,
  input wire logic        ANALOG_OUT_CH0_OE_O, ANALOG_OUT_CH1_OE_O,
  input wire logic        PIN_A_FUNCTION_SELECT_O, PORT_PIN_A_DATA_O,
  input wire logic [3:0]  PSTRB_I,
  input wire logic [7:0]  CH0_CODE_O, CH1_CODE_O,
  input wire logic [31:0] PADDR_I, PWDATA_I, PRDATA_O
);
  localparam logic [31:0] A_EN = 32'h0010_0918;
  localparam logic [31:0] A_VS = 32'h0010_091c;
  localparam logic [31:0] A_C1 = 32'h0010_0920;
  localparam logic [31:0] A_C0 = 32'h0010_0924;
  wire wr_done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0];
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_ready_once: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
    else $error("ready not one access cycle");
  a_enable_write: assert property (wr_done && PADDR_I == A_EN |=>
    {CH0_CONVERT_O, CH1_CONVERT_O} == $past(PWDATA_I[1:0])) else $error("enable write lost");
  a_code0_write: assert property (wr_done && PADDR_I == A_C0 |=>
    CH0_CODE_O == $past(PWDATA_I[7:0])) else $error("code 0 write lost");
  a_code1_write: assert property (wr_done && PADDR_I == A_C1 |=>
    CH1_CODE_O == $past(PWDATA_I[7:0])) else $error("code 1 write lost");
  a_vsel_write: assert property (wr_done && PADDR_I == A_VS |=>
    SUPPLY_5V_SELECT_O == $past(PWDATA_I[0])) else $error("voltage select lost");
  a_pin_drive: assert property (wr_done && PADDR_I == A_EN |=>
    {ANALOG_OUT_CH0_OE_O, ANALOG_OUT_CH1_OE_O} == $past(PWDATA_I[1:0]))
    else $error("pin drive differs from enable");
  a_enable_read: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == A_EN |=>
    PRDATA_O == {30'h0, CH0_CONVERT_O, CH1_CONVERT_O}) else $error("enable read wrong");
  a_port_masked: assert property (PIN_A_FUNCTION_SELECT_O [*3] |-> !PORT_PIN_A_DATA_O)
    else $error("analog pin reads nonzero");
  a_reset_clear: assert property (disable iff (1'h0) !RESETN_I |=>
    CH0_CODE_O == 8'h00 && CH1_CODE_O == 8'h00 && !CH0_CONVERT_O && !CH1_CONVERT_O && !SUPPLY_5V_SELECT_O)
    else $error("reset did not clear");
  c_both_on: cover property (wr_done && PADDR_I == A_EN && PWDATA_I[1:0] == 2'h3);
  c_slverr: cover property (PREADY_O && PSLVERR_O);
  c_pin_analog: cover property (PIN_A_FUNCTION_SELECT_O && CH0_CONVERT_O);
endmodule // dac_ctrl_sva

// *** bench/tb_top.sv ***
// Purpose: Directed bench for the DAC control block.
// Assumes: Zero-wait APB slave; pin bits need a clocked reset.
// Notes:   Reset is held three edges at start and five in rst; cold-start pin bits clear on the third.
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] A_EN = 32'h0010_0918;
  localparam logic [31:0] A_VS = 32'h0010_091c;
  localparam logic [31:0] A_C1 = 32'h0010_0920;
  localparam logic [31:0] A_C0 = 32'h0010_0924;
  localparam logic [31:0] A_PF = 32'h0010_0b00;
  localparam logic [31:0] A_PU = 32'h0010_0b10;
  logic CLK_I = 1'h0, RESETN_I = 1'h0, COLD_START_I = 1'h1, PSEL_I = 1'h0, PENABLE_I = 1'h0;
  logic PWRITE_I = 1'h0, PORT_PIN_A_I = 1'h1, PORT_PIN_B_I = 1'h1;
  logic [31:0] PADDR_I = 32'h0, PWDATA_I = 32'h0, PRDATA_O, rd;
  logic [3:0] PSTRB_I = 4'hf;
  logic [7:0] CH0_CODE_O, CH1_CODE_O;
  logic PREADY_O, PSLVERR_O, CH0_CONVERT_O, CH1_CONVERT_O, SUPPLY_5V_SELECT_O, err;
  logic ANALOG_OUT_CH0_OE_O, ANALOG_OUT_CH1_OE_O, PORT_PIN_A_DATA_O, PORT_PIN_B_DATA_O;
  logic PIN_A_FUNCTION_SELECT_O, PIN_B_FUNCTION_SELECT_O, PIN_A_PULLUP_ENABLE_O, PIN_B_PULLUP_ENABLE_O;
  int errors, checks, cyc;
  wire [3:0] en_st = {CH0_CONVERT_O, CH1_CONVERT_O, ANALOG_OUT_CH0_OE_O, ANALOG_OUT_CH1_OE_O};
  wire [3:0] pin_st = {PIN_A_FUNCTION_SELECT_O, PIN_B_FUNCTION_SELECT_O,
                       PIN_A_PULLUP_ENABLE_O, PIN_B_PULLUP_ENABLE_O};
  wire [1:0] pd = {PORT_PIN_A_DATA_O, PORT_PIN_B_DATA_O};
  dac_output_control i_dut (.*);
  initial forever #2 CLK_I = ~CLK_I;
  task results;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until the edge that samples ready high
  task xf(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    @(posedge CLK_I);
    PSEL_I <= 1'h1;
    PENABLE_I <= 1'h0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    PSTRB_I <= s;
    @(posedge CLK_I);
    PENABLE_I <= 1'h1;
    do @(posedge CLK_I); while (PREADY_O !== 1'h1);
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'h0;
    PENABLE_I <= 1'h0;
  endtask
  task wr(input logic [31:0] a, d);
    xf(1'h1, a, d, 4'hf);
    @(negedge CLK_I);
  endtask
  task rdc(input logic [31:0] a, e);
    xf(1'h0, a, 32'h0, 4'hf);
    chk(rd, e);
  endtask
  task rst(input logic c);
    @(posedge CLK_I);
    COLD_START_I <= c;
    @(posedge CLK_I);
    RESETN_I <= 1'h0;
    repeat (5) @(posedge CLK_I);
    RESETN_I <= 1'h1;
    @(negedge CLK_I);
  endtask
  task t_enable;
    wr(A_C0, 32'ha5);
    wr(A_C1, 32'h3c);
    rdc(A_C0, 32'ha5);
    rdc(A_C1, 32'h3c);
    wr(A_EN, 32'hfe);
    chk(en_st, 4'ha);
    chk(CH0_CODE_O, 8'ha5);
    rdc(A_EN, 32'h2);
    wr(A_EN, 32'h1);
    chk(en_st, 4'h5);
  endtask
  task t_live;
    logic [7:0] c[3] = '{8'h00, 8'hff, 8'h80};
    wr(A_EN, 32'h3);
    foreach (c[i])
    begin
      wr(A_C1, {24'h0, c[i]});
      chk(CH1_CODE_O, c[i]);
    end
    xf(1'h1, A_C1, 32'h55, 4'h0);
    @(negedge CLK_I);
    chk(CH1_CODE_O, 8'h80);
    chk(en_st, 4'hf);
    wr(A_EN, 32'h0);
  endtask
  task t_vsel;
    wr(A_VS, 32'hff);
    chk(SUPPLY_5V_SELECT_O, 1'h1);
    xf(1'h0, A_VS, 32'h0, 4'hf);
    chk(rd & 32'hffff_fffd, 32'h1);
    wr(A_VS, 32'h0);
    chk(SUPPLY_5V_SELECT_O, 1'h0);
  endtask
  task t_pins;
    wr(A_PF, 32'h18);
    chk(pin_st, 4'hc);
    repeat (4) @(negedge CLK_I);
    chk(pd, 2'h0);
    wr(A_PF, 32'h08);
    wr(A_PU, 32'h10);
    chk(pin_st, 4'h9);
    repeat (4) @(negedge CLK_I);
    chk(pd, 2'h1);
    @(posedge CLK_I);
    PORT_PIN_B_I <= 1'h0;
    repeat (4) @(negedge CLK_I);
    chk(pd, 2'h0);
    @(posedge CLK_I);
    PORT_PIN_B_I <= 1'h1;
    xf(1'h0, A_PU, 32'h0, 4'hf);
    chk(err, 1'h0);
    xf(1'h1, 32'h0010_0ffc, 32'h0, 4'hf);
    chk(err, 1'h1);
  endtask
  task t_hot;
    wr(A_EN, 32'h3);
    wr(A_C0, 32'h77);
    rst(1'h0);
    chk(pin_st, 4'h9);
    rdc(A_EN, 32'h0);
    rdc(A_C0, 32'h0);
    rst(1'h1);
    chk(pin_st, 4'h0);
  endtask
  always @(posedge CLK_I)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      results();
    end
  end
  initial
  begin
    repeat (3) @(posedge CLK_I);
    RESETN_I <= 1'h1;
    rdc(A_EN, 32'h0);
    rdc(A_VS, 32'h0);
    rdc(A_C0, 32'h0);
    chk(pin_st, 4'h0);
    t_enable();
    t_live();
    t_vsel();
    t_pins();
    t_hot();
    results();
  end
endmodule // tb_top
bind dac_output_control dac_ctrl_sva i_sva (.*);
